/* irq_enable_priority_regs.sv */
// Purpose: interrupt enable, priority and arbitration registers of the cpu
// Assumes: peripherals present level pending flags; cpu pulses ack and return
// Notes:   extended sources always arbitrate at the low level

`timescale 1ns/1ps

// Summary of operation
// - global gate bit 7 blocks all sources
// - bit 6 masks spi requests
// - bit 5 masks both timer2 overflow flags
// - bit 4 masks uart0 requests
// - bit 3 masks timer1 overflow flag
// - bit 2 masks external line 1
// - bit 1 masks timer0 overflow flag
// - bit 0 masks external line 0
// - priority bit 7 reads one, ignores writes
// - priority bits 6..0 choose high or low level
// - main registers at a8, b8, bit access
// - extended enable at e6, timer3 down to smbus0
// - high preempts low; high never preempted
// - high level first, then fixed source order
module irq_enable_priority_regs (
  input  wire logic        ref_clk,                   // system clock, 40 MHz
  input  wire logic        rst,                       // async reset, active high
  input  wire logic [7:0]  sfr_addr,                  // byte register address
  input  wire logic        sfr_wr,                    // byte write strobe
  input  wire logic [7:0]  sfr_wdata,                 // byte write data
  input  wire logic        sfr_rd,                    // byte read strobe
  output logic      [7:0]  sfr_rdata,                 // read data, one cycle later
  output logic             sfr_hit,                   // read hit this block
  input  wire logic [7:0]  bit_addr,                  // bit address for bit access
  input  wire logic        bit_wr,                    // single-bit write strobe
  input  wire logic        bit_wval,                  // single-bit write value
  input  wire logic        bit_rd,                    // single-bit read strobe
  output logic             bit_rdata,                 // single-bit read value
  input  wire logic        external_request_line0,    // external line 0 pending
  input  wire logic        timer0_overflow_flag,      // timer 0 pending
  input  wire logic        external_request_line1,    // external line 1 pending
  input  wire logic        timer1_overflow_flag,      // timer 1 pending
  input  wire logic        uart0_pending,             // uart0 pending
  input  wire logic        timer2_low_overflow_flag,  // timer 2 low byte pending
  input  wire logic        timer2_high_overflow_flag, // timer 2 high byte pending
  input  wire logic        spi_pending,               // spi pending
  input  wire logic [7:0]  ext_pending,               // smbus0 .. timer3 pending
  input  wire logic        irq_ack,                   // cpu enters offered service
  input  wire logic        irq_return,                // cpu leaves a service routine
  output logic [14:0]      src_request,               // gated per-source requests
  output logic             irq_req,                   // request offered to cpu
  output logic [3:0]       irq_index,                 // order of offered source
  output logic             irq_high                   // offered source is high level
);

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [7:0]  irq_enable_main_reg;
  logic [6:0]  irq_priority_main_reg;
  logic [7:0]  irq_enable_extended_first_reg;
  logic        serve_low_reg;
  logic        serve_high_reg;
  logic [7:0]  prio_view;
  logic [14:0] pend_raw;
  logic [14:0] mask_all;
  logic [14:0] level_all;
  logic [14:0] req_next;
  logic        win_next;
  logic        win_high_next;
  logic [3:0]  win_index_next;
  logic        bit_hit_en;
  logic        bit_hit_pr;
  logic [2:0]  bit_sel;

  // priority register view: unused top bit reads one
  assign prio_view = {irq_gate_pkg::RST_PRIORITY_MAIN[irq_gate_pkg::PRIO_UNUSED_BIT],
                      irq_priority_main_reg};

  // bit address decode: upper five bits select the register
  assign bit_sel    = bit_addr[2:0];
  assign bit_hit_en = (bit_addr[7:3] ==
                       irq_gate_pkg::ADDR_ENABLE_MAIN[7:3]);
  assign bit_hit_pr = (bit_addr[7:3] ==
                       irq_gate_pkg::ADDR_PRIORITY_MAIN[7:3]);

  // ---------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------
  // main enable: byte write or single-bit write, on every page
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_enable_main_reg <= irq_gate_pkg::RST_ENABLE_MAIN;
    end else if (sfr_wr && sfr_addr == irq_gate_pkg::ADDR_ENABLE_MAIN) begin
      irq_enable_main_reg <= sfr_wdata;
    end else if (bit_wr && bit_hit_en) begin
      irq_enable_main_reg[bit_sel] <= bit_wval;
    end
  end

  // main priority: only bits 6..0 are stored, bit 7 writes dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_priority_main_reg <=
        irq_gate_pkg::RST_PRIORITY_MAIN[irq_gate_pkg::MAIN_SOURCE_BITS-1:0];
    end else if (sfr_wr && sfr_addr == irq_gate_pkg::ADDR_PRIORITY_MAIN) begin
      irq_priority_main_reg <= sfr_wdata[irq_gate_pkg::MAIN_SOURCE_BITS-1:0];
    end else if (bit_wr && bit_hit_pr &&
                 bit_sel != 3'(irq_gate_pkg::PRIO_UNUSED_BIT)) begin
      irq_priority_main_reg[bit_sel] <= bit_wval;
    end
  end

  // extended enable: byte access only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_enable_extended_first_reg <= irq_gate_pkg::RST_ENABLE_EXT;
    end else if (sfr_wr && sfr_addr == irq_gate_pkg::ADDR_ENABLE_EXT) begin
      irq_enable_extended_first_reg <= sfr_wdata;
    end
  end

  // ---------------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------------
  // byte read data and hit flag, registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= irq_gate_pkg::RD_UNMAPPED;
      sfr_hit   <= 1'b0;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        irq_gate_pkg::ADDR_ENABLE_MAIN: begin
          sfr_rdata <= irq_enable_main_reg;
          sfr_hit   <= 1'b1;
        end
        irq_gate_pkg::ADDR_PRIORITY_MAIN: begin
          sfr_rdata <= prio_view;
          sfr_hit   <= 1'b1;
        end
        irq_gate_pkg::ADDR_ENABLE_EXT: begin
          sfr_rdata <= irq_enable_extended_first_reg;
          sfr_hit   <= 1'b1;
        end
        default: begin
          sfr_rdata <= irq_gate_pkg::RD_UNMAPPED;
          sfr_hit   <= 1'b0;
        end
      endcase
    end else begin
      sfr_hit <= 1'b0;
    end
  end

  // single-bit read, zero when not ours
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_rdata <= 1'b0;
    end else if (bit_rd) begin
      bit_rdata <= (bit_hit_en && irq_enable_main_reg[bit_sel]) ||
                   (bit_hit_pr && prio_view[bit_sel]);
    end
  end

  // ---------------------------------------------------------------------
  // request gating
  // ---------------------------------------------------------------------
  // pending flags and masks in source order
  always_comb begin
    pend_raw = '0;
    pend_raw[irq_gate_pkg::SRC_EXT0]   = external_request_line0;
    pend_raw[irq_gate_pkg::SRC_TIMER0] = timer0_overflow_flag;
    pend_raw[irq_gate_pkg::SRC_EXT1]   = external_request_line1;
    pend_raw[irq_gate_pkg::SRC_TIMER1] = timer1_overflow_flag;
    pend_raw[irq_gate_pkg::SRC_UART0]  = uart0_pending;
    pend_raw[irq_gate_pkg::SRC_TIMER2] = timer2_low_overflow_flag |
                                         timer2_high_overflow_flag;
    pend_raw[irq_gate_pkg::SRC_SPI]    = spi_pending;
    pend_raw[irq_gate_pkg::NUM_SOURCES-1:irq_gate_pkg::SRC_EXT_BASE] = ext_pending;
    // bits 6..0 of the main enable line up with sources 6..0
    mask_all = {irq_enable_extended_first_reg,
                irq_enable_main_reg[irq_gate_pkg::MAIN_SOURCE_BITS-1:0]};
    level_all = {8'h00, irq_priority_main_reg};
    req_next  = pend_raw & mask_all &
                {irq_gate_pkg::NUM_SOURCES{
                  irq_enable_main_reg[irq_gate_pkg::GLOBAL_GATE_BIT]}};
  end

  // ---------------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------------
  // high level first, lowest order wins within a level
  always_comb begin
    win_next       = 1'b0;
    win_high_next  = 1'b0;
    win_index_next = '0;
    for (int i = irq_gate_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
      if (req_next[i] && !level_all[i] && !win_high_next) begin
        win_next       = 1'b1;
        win_index_next = 4'(i);
      end
    end
    for (int i = irq_gate_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
      if (req_next[i] && level_all[i]) begin
        win_next       = 1'b1;
        win_high_next  = 1'b1;
        win_index_next = 4'(i);
      end
    end
    // only a high request may interrupt a low routine; nothing beats high
    if (serve_high_reg || (serve_low_reg && !win_high_next)) begin
      win_next = 1'b0;
    end
  end

  // registered offer to the cpu
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_request <= '0;
      irq_req     <= 1'b0;
      irq_index   <= '0;
      irq_high    <= 1'b0;
    end else begin
      src_request <= req_next;
      irq_req     <= win_next;
      irq_index   <= win_index_next;
      irq_high    <= win_high_next;
    end
  end

  // ---------------------------------------------------------------------
  // in-service tracking
  // ---------------------------------------------------------------------
  // ack enters the offered level; return leaves the innermost level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serve_low_reg  <= 1'b0;
      serve_high_reg <= 1'b0;
    end else if (irq_ack && irq_req) begin
      if (irq_high) begin
        serve_high_reg <= 1'b1;
      end else begin
        serve_low_reg <= 1'b1;
      end
    end else if (irq_return) begin
      if (serve_high_reg) begin
        serve_high_reg <= 1'b0;
      end else begin
        serve_low_reg <= 1'b0;
      end
    end
  end

endmodule

/* irq_gate_pkg.sv */
// Purpose: shared constants for the interrupt enable and priority block
// Assumes: 8-bit special function register bus with bit-addressable registers
// Notes:   source order numbers double as fixed arbitration order

package irq_gate_pkg;

  // ---------------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE_MAIN   = 8'ha8;
  localparam logic [7:0] ADDR_PRIORITY_MAIN = 8'hb8;
  localparam logic [7:0] ADDR_ENABLE_EXT    = 8'he6;

  // bit address base of a bit-addressable register is its byte address
  localparam logic [4:0] BIT_BASE_MASK      = 5'h1f;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_ENABLE_MAIN    = 8'h00;
  localparam logic [7:0] RST_PRIORITY_MAIN  = 8'h80;
  localparam logic [7:0] RST_ENABLE_EXT     = 8'h00;
  localparam logic [7:0] RD_UNMAPPED        = 8'h00;

  // ---------------------------------------------------------------------
  // field positions in the main enable and priority registers
  // ---------------------------------------------------------------------
  localparam int GLOBAL_GATE_BIT    = 7;
  localparam int PRIO_UNUSED_BIT    = 7;
  localparam int MAIN_SOURCE_BITS   = 7;   // bits 6..0 of enable and priority

  // ---------------------------------------------------------------------
  // source order (index external_request_line0 pending vector)
  // ---------------------------------------------------------------------
  localparam int SRC_EXT0     = 0;
  localparam int SRC_TIMER0   = 1;
  localparam int SRC_EXT1     = 2;
  localparam int SRC_TIMER1   = 3;
  localparam int SRC_UART0    = 4;
  localparam int SRC_TIMER2   = 5;
  localparam int SRC_SPI      = 6;
  localparam int SRC_EXT_BASE = 7;       // smbus0 .. timer3 at 7..14
  localparam int NUM_SOURCES  = 15;
  localparam int INDEX_W      = 4;

endpackage

/* irq_gate_checker.sv */
// Purpose: port assertions for the interrupt enable and priority block
// Assumes: one clock, async active-high reset
// Notes:   sees only the ports of the block
`timescale 1ns/1ps
module irq_gate_checker (
  input wire logic ref_clk, rst, sfr_wr, sfr_rd, sfr_hit, bit_wr, bit_wval, bit_rd,
  input wire logic bit_rdata, external_request_line0, timer0_overflow_flag,
  input wire logic external_request_line1, timer1_overflow_flag, uart0_pending,
  input wire logic timer2_low_overflow_flag, timer2_high_overflow_flag, spi_pending,
  input wire logic irq_ack, irq_return, irq_req, irq_high,
  input wire logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, bit_addr, ext_pending,
  input wire logic [14:0] src_request,
  input wire logic [3:0]  irq_index
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [14:0] flags;
  // pending flags in source order, timer 2 merged
  assign flags = {ext_pending, spi_pending, timer2_low_overflow_flag | timer2_high_overflow_flag,
                  uart0_pending, timer1_overflow_flag, external_request_line1,
                  timer0_overflow_flag, external_request_line0};
  flag_needed_a: assert property ((src_request & ~$past(flags)) == 15'h0)
    else $error("request without pending flag");
  main_gate_a: assert property (
    sfr_wr && sfr_addr == 8'ha8 |-> ##2
    (src_request & ~({8'hff, $past(sfr_wdata[6:0], 2)} & {15{$past(sfr_wdata[7], 2)}})) == 15'h0)
    else $error("request passed a cleared enable");
  ext_gate_a: assert property (sfr_wr && sfr_addr == 8'he6 |-> ##2
    (src_request[14:7] & ~$past(sfr_wdata, 2)) == 8'h00) else $error("extended mask ignored");
  prio_top_a: assert property (
    sfr_rd && sfr_addr == 8'hb8 |=> sfr_hit && sfr_rdata[7])
    else $error("priority bit 7 not one");
  prio_bit_a: assert property (bit_rd && bit_addr == 8'hbf |=> bit_rdata)
    else $error("priority bit 7 bit read not one");
  unmapped_read_a: assert property (
    sfr_rd && !(sfr_addr inside {8'ha8, 8'hb8, 8'he6})
    |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped read answered");
  main_readback_a: assert property (sfr_wr && sfr_addr == 8'ha8 ##1
    sfr_rd && sfr_addr == 8'ha8 && !sfr_wr && !bit_wr |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("enable readback wrong");
  offer_valid_a: assert property (irq_req |-> src_request[irq_index])
    else $error("offered source not requesting");
  low_order_a: assert property (irq_req && !irq_high |->
    (src_request & ((15'h1 << irq_index) - 15'h1)) == 15'h0) else $error("low winner not first");
  ext_level_a: assert property (irq_req && irq_high |-> irq_index < 4'd7)
    else $error("extended source offered high");
  high_hold_a: assert property (irq_req && irq_ack && irq_high |-> ##2 !irq_req)
    else $error("high service preempted");
  low_hold_a: assert property (
    irq_req && irq_ack && !irq_high |-> ##2 (!irq_req || irq_high))
    else $error("low service preempted by low");
endmodule

/* tb_irq_enable_priority_regs.sv */
// Purpose: self-checking bench for the interrupt enable and priority block
// Assumes: inputs driven at falling edge, fixed one-cycle answers
// Notes:   expected results queued by the driver, popped by the watcher
`timescale 1ns/1ps
module tb_irq_enable_priority_regs;
  logic        ref_clk = 1'b0, rst = 1'b1, ob = 1'b0, rd_d, bt_d, ob_d;
  logic [5:0]  k = 6'h00;  // wr rd bit_wr bit_rd ack return
  logic [7:0]  a = 8'h00, d = 8'h00, sfr_rdata;
  logic [15:0] p = 16'h0000, pv = 16'h0000;
  logic [14:0] src_request;
  logic [3:0]  irq_index;
  logic        sfr_hit, bit_rdata, irq_req, irq_high;
  int          mismatches = 0, checks = 0;
  logic [8:0]  q_rd[$];
  logic        q_bt[$];
  logic [20:0] q_irq[$];
  irq_enable_priority_regs dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(a), .sfr_wr(k[5]),
    .sfr_wdata(d), .sfr_rd(k[4]), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .bit_addr(a),
    .bit_wr(k[3]), .bit_wval(d[0]), .bit_rd(k[2]), .bit_rdata(bit_rdata),
    .external_request_line0(p[0]), .timer0_overflow_flag(p[1]), .external_request_line1(p[2]),
    .timer1_overflow_flag(p[3]), .uart0_pending(p[4]), .timer2_low_overflow_flag(p[5]),
    .timer2_high_overflow_flag(p[15]), .spi_pending(p[6]), .ext_pending(p[14:7]),
    .irq_ack(k[1]), .irq_return(k[0]), .src_request(src_request), .irq_req(irq_req),
    .irq_index(irq_index), .irq_high(irq_high));
  initial forever #12.5 ref_clk = ~ref_clk;
  // expected offer: gated flags, lowest high source, else lowest source
  function automatic logic [20:0] model(input logic [7:0] en, pr, ex, input logic [15:0] pp);
    logic [14:0] s, h;
    logic [20:0] r;
    s = {pp[14:6], pp[5] | pp[15], pp[4:0]} & {ex, en[6:0]} & {15{en[7]}};
    h = s & {8'h00, pr[6:0]};
    r = {s, 6'h00};
    for (int i = 14; i >= 0; i--) if (s[i]) r[5:0] = {1'b1, 4'(i), 1'b0};
    for (int i = 6; i >= 0; i--) if (h[i]) r[5:0] = {1'b1, 4'(i), 1'b1};
    return r;
  endfunction
  task automatic cyc(input logic [5:0] kk, input logic [7:0] aa, dd, input logic oo);
    @(negedge ref_clk);
    k = kk; a = aa; d = dd; p = pv; ob = oo;
  endtask
  task automatic rd(input logic [7:0] aa, input logic [8:0] e);
    q_rd.push_back(e); cyc(6'h10, aa, 8'h00, 1'b0);
  endtask
  task automatic br(input logic [7:0] aa, input logic e);
    q_bt.push_back(e); cyc(6'h04, aa, 8'h00, 1'b0);
  endtask
  task automatic chk(input logic [20:0] e);
    q_irq.push_back(e); cyc(6'h00, 8'h00, 8'h00, 1'b1);
  endtask
  task automatic svc(input logic [5:0] kk);
    cyc(kk, 8'h00, 8'h00, 1'b0); cyc(6'h00, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic bad(input string m);
    mismatches++;
    $display("BAD %0t %s", $time, m);
  endtask
  // one compare task per kind of result
  task automatic cmp_rd(input logic [8:0] e);
    checks++;
    if ({sfr_hit, sfr_rdata} !== e) bad($sformatf("byte read %h want %h", sfr_rdata, e));
  endtask
  task automatic cmp_bt(input logic e);
    checks++;
    if (bit_rdata !== e) bad("bit read wrong");
  endtask
  task automatic cmp_irq(input logic [20:0] e);
    checks++;
    if (src_request !== e[20:6] || irq_req !== e[5] || (e[5] && {irq_index, irq_high} !== e[4:0]))
      bad($sformatf("offer %h %b %h want %h", src_request, irq_req, irq_index, e));
  endtask
  task automatic fin(input string m);
    svc(6'h00);
    $display("test done: %s", m);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watcher: note which results appear after each edge
  always @(posedge ref_clk) begin
    rd_d <= k[4]; bt_d <= k[2]; ob_d <= ob;
  end
  // watcher: compare settled outputs with the oldest note
  always @(negedge ref_clk) begin
    if (rd_d === 1'b1) cmp_rd(q_rd.pop_front());
    if (bt_d === 1'b1) cmp_bt(q_bt.pop_front());
    if (ob_d === 1'b1) cmp_irq(q_irq.pop_front());
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    bad("timeout");
    report_and_stop;
  end
  // main sequence
  initial begin
    logic [7:0] en, pr, ex;
    void'($urandom(52478));
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    rd(8'ha8, 9'h100);
    rd(8'hb8, 9'h180);
    rd(8'he6, 9'h100);
    rd(8'h5a, 9'h000);
    br(8'hbf, 1'b1);
    fin("reset values");
    repeat (12) begin
      en = 8'($urandom); pr = 8'($urandom); ex = 8'($urandom);
      cyc(6'h20, 8'hb8, pr, 1'b0); cyc(6'h20, 8'he6, ex, 1'b0); cyc(6'h20, 8'ha8, en, 1'b0);
      rd(8'ha8, {1'b1, en});
      rd(8'hb8, {2'b11, pr[6:0]});
      rd(8'he6, {1'b1, ex});
      pv = 16'($urandom);
      chk(model(en, pr, ex, pv));
    end
    fin("random gating");
    cyc(6'h20, 8'ha8, 8'h00, 1'b0); cyc(6'h20, 8'hb8, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++) cyc(6'h08, 8'ha8 + 8'(i), {7'h0, i[0]}, 1'b0);
    cyc(6'h08, 8'hbf, 8'h00, 1'b0); cyc(6'h08, 8'hb9, 8'h01, 1'b0);
    for (int i = 0; i < 8; i++) br(8'ha8 + 8'(i), i[0]);
    rd(8'ha8, 9'h1aa);
    rd(8'hb8, 9'h182);
    fin("bit access");
    cyc(6'h20, 8'ha8, 8'h87, 1'b0); cyc(6'h20, 8'hb8, 8'h04, 1'b0);
    pv = 16'h0001;
    chk({15'h0001, 6'b1_0000_0});
    svc(6'h02);
    chk({15'h0001, 6'h00});
    pv = 16'h0007;
    chk({15'h0007, 6'b1_0010_1});
    svc(6'h02);
    chk({15'h0007, 6'h00});
    pv = 16'h0003;
    svc(6'h01);
    chk({15'h0003, 6'h00});
    svc(6'h01);
    chk({15'h0003, 6'b1_0000_0});
    fin("nesting");
    // reset in mid-run while a low routine is in service
    svc(6'h02);
    rst = 1'b1;
    svc(6'h00);
    rst = 1'b0;
    rd(8'ha8, 9'h100);
    rd(8'hb8, 9'h180);
    chk({15'h0000, 6'h00});
    cyc(6'h20, 8'ha8, 8'h81, 1'b0);
    chk({15'h0001, 6'b1_0000_0});
    fin("mid-run reset");
    report_and_stop;
  end
endmodule
bind irq_enable_priority_regs irq_gate_checker chk_i (.ref_clk, .rst, .sfr_wr, .sfr_rd,
  .sfr_hit, .bit_wr, .bit_wval, .bit_rd, .bit_rdata, .external_request_line0,
  .timer0_overflow_flag, .external_request_line1, .timer1_overflow_flag, .uart0_pending,
  .timer2_low_overflow_flag, .timer2_high_overflow_flag, .spi_pending, .irq_ack, .irq_return,
  .irq_req, .irq_high, .sfr_addr, .sfr_wdata, .sfr_rdata, .bit_addr, .ext_pending,
  .src_request, .irq_index);
